// File: hdl/fpet_pkg.sv
// Package of constants for the flash program/erase timer
package fpet_pkg;
  // Divider field
  localparam int unsigned DIV_W = 7;
  localparam logic [DIV_W-1:0] DIV_RST = 7'h00;
  // Bus clock and timing clock window
  localparam int unsigned BUS_CLK_HZ = 250000000;
  localparam int unsigned FLASH_TIMING_CLOCK_MIN_HZ = 150000;
  localparam int unsigned FLASH_TIMING_CLOCK_MAX_HZ = 200000;
  // Command encodings
  localparam logic [1:0] CMD_BYTE = 2'h0;
  localparam logic [1:0] CMD_BURST = 2'h1;
  localparam logic [1:0] CMD_PAGE = 2'h2;
  localparam logic [1:0] CMD_MASS = 2'h3;
  // Timing counts in timing clock periods
  localparam int unsigned CNT_W = 15;
  localparam logic [CNT_W-1:0] CYC_BYTE = 15'h0009;
  localparam logic [CNT_W-1:0] CYC_BURST = 15'h0004;
  localparam logic [CNT_W-1:0] CYC_PAGE = 15'h0FA0;
  localparam logic [CNT_W-1:0] CYC_MASS = 15'h4E20;
  // Array organisation
  localparam int unsigned PAGE_BYTES = 512;
  localparam int unsigned PAGE_COUNT = 32;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned PAGE_LSB = 9;
  // Prescaler: divide by eight when the prescale bit is set
  localparam int unsigned PRE_W = 3;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } fpet_state_t;
endpackage : fpet_pkg

// File: hdl/fpet_tick_gen.sv
// Timing clock tick generator from bus clock and divider
`timescale 1ns/100ps
module fpet_tick_gen (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Divider setting
  input wire logic run_i,
  input wire logic prescale_i,
  input wire logic [fpet_pkg::DIV_W-1:0] div_i,
  // Tick out
  output logic tick_o
);
  logic [fpet_pkg::PRE_W-1:0] pre_q;
  logic [fpet_pkg::DIV_W-1:0] cnt_q;
  wire pre_wrap = !prescale_i || (pre_q == '1);
  wire cnt_wrap = pre_wrap && (cnt_q == div_i);
  // Rate is bus clock / ((div+1) * (prescale ? 8 : 1))
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pre_q <= '0;
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      pre_q <= run_i ? pre_q + 1'b1 : '0;
      if (!run_i || cnt_wrap)
        cnt_q <= '0;
      else if (pre_wrap)
        cnt_q <= cnt_q + 1'b1;
      tick_o <= run_i && cnt_wrap;
    end
  end
endmodule : fpet_tick_gen

// File: hdl/fpet_core.sv
// Flash program/erase timing core: divider, error flag, pulse sequencer
`timescale 1ns/100ps
module fpet_core (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Divider write
  input wire logic div_wr_i,
  input wire logic div_prescale_i,
  input wire logic [fpet_pkg::DIV_W-1:0] div_data_i,
  // Error flag clear
  input wire logic err_clr_i,
  // Command request
  input wire logic cmd_req_i,
  input wire logic [1:0] cmd_i,
  input wire logic [fpet_pkg::ADDR_W-1:0] cmd_addr_i,
  // Status
  output logic div_loaded_o,
  output logic [fpet_pkg::DIV_W-1:0] div_value_o,
  output logic div_prescale_o,
  output logic access_error_flag_o,
  output logic busy_o,
  output logic done_o,
  // High voltage and target
  output logic hv_en_o,
  output logic erase_o,
  output logic mass_o,
  output logic [fpet_pkg::PAGE_W-1:0] page_o,
  output logic [fpet_pkg::ADDR_W-1:0] prog_addr_o
);
  fpet_pkg::fpet_state_t state_q;
  fpet_pkg::fpet_state_t state_d;
  logic [fpet_pkg::CNT_W-1:0] cnt_q;
  logic tick;

  // Timing clock derived from bus clock and divider
  // The tick phase runs free once the divider is loaded,
  // so the first period of a command may be up to one tick short;
  // software picks the divider for the 150-200 kHz window
  fpet_tick_gen u_tick (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .run_i(div_loaded_o),
    .prescale_i(div_prescale_o),
    .div_i(div_value_o),
    .tick_o(tick)
  );

  // Write acceptance decode
  wire div_take = div_wr_i && !div_loaded_o && !access_error_flag_o;
  wire cmd_refuse = cmd_req_i && (!div_loaded_o || state_q != fpet_pkg::ST_IDLE);
  wire cmd_take = cmd_req_i && !cmd_refuse;
  wire cnt_end = tick && (cnt_q == 15'h0001);

  // Period count per command
  logic [fpet_pkg::CNT_W-1:0] cmd_cycles;
  always_comb
  begin
    case (cmd_i)
      fpet_pkg::CMD_BYTE:
      begin
        cmd_cycles = fpet_pkg::CYC_BYTE;
      end
      fpet_pkg::CMD_BURST:
      begin
        cmd_cycles = fpet_pkg::CYC_BURST;
      end
      fpet_pkg::CMD_PAGE:
      begin
        cmd_cycles = fpet_pkg::CYC_PAGE;
      end
      fpet_pkg::CMD_MASS:
      begin
        cmd_cycles = fpet_pkg::CYC_MASS;
      end
      default:
      begin
        cmd_cycles = fpet_pkg::CYC_BYTE;
      end
    endcase
  end

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fpet_pkg::ST_IDLE:
      begin
        if (cmd_take)
          state_d = fpet_pkg::ST_BUSY;
      end
      fpet_pkg::ST_BUSY:
      begin
        // Leave only on the tick that ends the last period
        if (cnt_end)
          state_d = fpet_pkg::ST_DONE;
      end
      fpet_pkg::ST_DONE:
      begin
        state_d = fpet_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = fpet_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state decode
  wire in_busy = (state_q == fpet_pkg::ST_BUSY);
  wire next_busy = (state_d == fpet_pkg::ST_BUSY);
  wire next_done = (state_d == fpet_pkg::ST_DONE);
  wire cnt_step = in_busy && tick;

  // Divider loaded flag, set once and held until reset
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      div_loaded_o <= 1'b0;
    else if (div_take)
      div_loaded_o <= 1'b1;
  end

  // Divider value and prescale, captured with the flag
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      div_value_o <= fpet_pkg::DIV_RST;
      div_prescale_o <= 1'b0;
    end
    else if (div_take)
    begin
      div_value_o <= div_data_i;
      div_prescale_o <= div_prescale_i;
    end
  end

  // Access error flag, set wins over clear
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      access_error_flag_o <= 1'b0;
    else if (cmd_refuse)
      access_error_flag_o <= 1'b1;
    else if (err_clr_i)
      access_error_flag_o <= 1'b0;
  end

  // Sequencer state register
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_q <= fpet_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // Period counter, loaded at take and stepped on each tick while busy
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_q <= '0;
    else if (cmd_take)
      cnt_q <= cmd_cycles;
    else if (cnt_step)
      cnt_q <= cnt_q - 1'b1;
  end

  // Status outputs, registered from the next state
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      busy_o <= 1'b0;
      hv_en_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      busy_o <= next_busy;
      hv_en_o <= next_busy;
      done_o <= next_done;
    end
  end

  // Command type and target, held from one take to the next
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      erase_o <= 1'b0;
      mass_o <= 1'b0;
      page_o <= '0;
      prog_addr_o <= '0;
    end
    else if (cmd_take)
    begin
      erase_o <= cmd_i[1];
      mass_o <= (cmd_i == fpet_pkg::CMD_MASS);
      page_o <= cmd_addr_i[fpet_pkg::ADDR_W-1:fpet_pkg::PAGE_LSB];
      prog_addr_o <= cmd_addr_i;
    end
  end
endmodule : fpet_core

// File: tb/fpet_core_assertions.sv
// Checker of the flash program/erase timer core
`timescale 1ns/100ps
module fpet_core_chk (
  // Watched ports
  input wire logic clk_sys_i, nrst_i, div_wr_i, cmd_req_i, div_loaded_o, access_error_flag_o,
  input wire logic busy_o, done_o, hv_en_o, erase_o, mass_o,
  input wire logic [1:0] cmd_i,
  input wire logic [6:0] div_data_i, div_value_o,
  input wire logic [13:0] cmd_addr_i,
  input wire logic [4:0] page_o
);
  // One clock domain
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  a_div_take: assert property (
    div_wr_i && !div_loaded_o && !access_error_flag_o |=> div_loaded_o && div_value_o == $past(div_data_i))
    else $error("divider not taken");
  a_div_once: assert property (div_loaded_o |=> $stable(div_value_o))
    else $error("divider changed");
  a_err_block: assert property (access_error_flag_o && !div_loaded_o |=> !div_loaded_o)
    else $error("divider taken with error");
  a_early_cmd: assert property (cmd_req_i && !div_loaded_o |=> access_error_flag_o && !busy_o)
    else $error("early command not refused");
  a_cmd_take: assert property (
    cmd_req_i && div_loaded_o && !busy_o && !done_o |=> busy_o && page_o == $past(cmd_addr_i[13:9])
    && erase_o == $past(cmd_i[1]) && mass_o == ($past(cmd_i) == 2'h3))
    else $error("command not taken");
  a_hv_busy: assert property (hv_en_o == busy_o)
    else $error("high voltage off busy");
  a_busy_min: assert property ($rose(busy_o) |-> busy_o [*4])
    else $error("command too short");
  a_done_end: assert property ($fell(busy_o) |-> done_o)
    else $error("no done at end");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done too long");
  // Main scenarios
  c_mass: cover property ($fell(busy_o) && mass_o);
  c_early: cover property (cmd_req_i && !div_loaded_o);
  c_load: cover property ($rose(div_loaded_o));
endmodule : fpet_core_chk
bind fpet_core fpet_core_chk u_chk (.*);

// File: tb/test_flash_program_erase_timer.sv
// Bench for the flash program/erase timer core
`timescale 1ns/100ps
module test_flash_program_erase_timer;
  logic clk_sys_i = 0, nrst_i = 0, div_wr_i = 0, div_prescale_i = 0, err_clr_i = 0, cmd_req_i = 0;
  logic [6:0] div_data_i = 7'h00;
  logic [1:0] cmd_i = 2'h0;
  logic [13:0] cmd_addr_i = 14'h0000;
  logic div_loaded_o, div_prescale_o, access_error_flag_o, busy_o, done_o, hv_en_o, erase_o, mass_o;
  logic [6:0] div_value_o;
  logic [4:0] page_o;
  logic [13:0] prog_addr_o;
  int fails = 0, checks_done = 0;
  // Bus clock, 4 ns period
  always #2 clk_sys_i = ~clk_sys_i;
  fpet_core dut_u (.*);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value at %0t: saw %0h want %0h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // One-cycle strobe: 0 divider write, 1 error clear, 2 command
  task automatic pulse(input int w);
    @(negedge clk_sys_i);
    {cmd_req_i, err_clr_i, div_wr_i} = 3'b001 << w;
    @(negedge clk_sys_i);
    {cmd_req_i, err_clr_i, div_wr_i} = 3'b000;
  endtask : pulse
  // Early command, blocked write, first write, ignored rewrite
  task automatic t_setup;
    pulse(2);
    chk(access_error_flag_o, 1);
    chk(busy_o, 0);
    div_data_i = 7'h01;
    pulse(0);
    chk(div_loaded_o, 0);
    pulse(1);
    pulse(0);
    chk({div_loaded_o, div_value_o}, 8'h81);
    chk(div_prescale_o, 0);
    div_data_i = 7'h05;
    pulse(0);
    chk(div_value_o, 1);
    $display("test setup done");
  endtask : t_setup
  // Tick is two bus cycles; the first tick may be partial
  task automatic t_cmd(input logic [1:0] c, input int n);
    int k;
    cmd_i = c;
    cmd_addr_i = 14'h3E05;
    pulse(2);
    chk({erase_o, mass_o, page_o}, {c[1], c == 2'h3, 5'h1F});
    chk(prog_addr_o, 14'h3E05);
    chk(hv_en_o, 1);
    for (k = 1; busy_o === 1'b1 && k < 50000; k++)
      @(negedge clk_sys_i);
    if (k == 50000)
    begin
      fails++;
      give_verdict;
    end
    chk(k >= 2 * n && k <= 2 * n + 1, 1);
    chk(done_o, 1);
    @(negedge clk_sys_i);
    $display("test command %0d done", c);
  endtask : t_cmd
  // Main sequence
  initial
  begin
    repeat (12) @(negedge clk_sys_i);
    nrst_i = 1;
    t_setup;
    t_cmd(2'h0, 9);
    t_cmd(2'h1, 4);
    t_cmd(2'h2, 4000);
    t_cmd(2'h3, 20000);
    give_verdict;
  end
endmodule : test_flash_program_erase_timer
